/* File: verilog/uart_sup_cfg.svh */
// constants for the receive supervision block: register map, fields, resets
// assumes inclusion by the package and the top module only
`ifndef UART_SUP_CFG_SVH
`define UART_SUP_CFG_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define ADDR_W 4
`define DATA_W 8
`define CNT_W 16

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL_ZERO 4'h0
`define REG_CTRL_ONE 4'h1
`define REG_IRQ_FLAG 4'h2
`define REG_ERR_FLAG 4'h3
`define REG_ERR_ENABLE 4'h4
`define REG_PERIPH_IE 4'h5
`define REG_IRQ_CTRL 4'h6
`define REG_DIV_LOW 4'h7
`define REG_DIV_HIGH 4'h8
`define REG_IRQ_MASK 4'h9

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_AB_EN 0
`define BIT_WUE 0
`define BIT_RX_IDLE 1
`define BIT_AB_DONE 0
`define BIT_WAKE 1
`define BIT_AB_OVF 0
`define BIT_AB_OVF_IE 0
`define BIT_PORT_IE 0
`define BIT_PORT_ERR_IE 1
`define BIT_PIE 0
`define BIT_GIE 1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define DIV_RESET 16'h0000
`define MASK_RESET 2'h3
`define CNT_MAX 16'hffff
`define FIFTH_EDGE 3'h4
`define EDGE_ONE 3'h1

`endif

/* File: verilog/uart_sup_pkg.sv */
// types for the receive supervision block
// assumes uart_sup_cfg.svh on the include path
package uart_sup_pkg;
`include "uart_sup_cfg.svh"

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'b00,
    AB_WAIT_FIRST = 2'b01,
    AB_MEASURE = 2'b10
  } ab_state_t;

  typedef enum logic [1:0] {
    WK_OFF = 2'b00,
    WK_WATCH = 2'b01,
    WK_BREAK = 2'b10
  } wk_state_t;

  typedef struct packed {
    logic meta;
    logic level;
    logic prev;
  } sync_state_t;

  typedef struct packed {
    ab_state_t ab_state;
    logic autobaud_enable;
    logic [`CNT_W-1:0] ab_cnt;
    logic [2:0] edge_cnt;
    logic ovf_seen;
    logic autobaud_done_flag;
    logic autobaud_overflow_flag;
    wk_state_t wk_state;
    logic wake_on_break_enable;
    logic wake_event_flag;
    logic autobaud_overflow_irq_enable;
    logic port_irq_enable;
    logic port_error_irq_enable;
    logic peripheral_irq_global_enable;
    logic global_irq_enable;
    logic [1:0] irq_mask;
    logic [`CNT_W-1:0] baud_div;
    logic [`DATA_W-1:0] rdata;
    logic irq;
    logic rx_enable;
  } sup_state_t;
endpackage : uart_sup_pkg

/* File: verilog/rx_line_sync.sv */
// two-flop synchroniser for the receive pin with edge pulses
// assumes rx_pin is asynchronous to core_clk; idle level is high
`timescale 1ns/1ps
module rx_line_sync
  import uart_sup_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rx_pin,
  output logic rx_level,
  output logic rx_fall,
  output logic rx_rise
);
  sync_state_t s_q;
  sync_state_t s_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.meta = rx_pin;
    s_d.level = s_q.meta;
    s_d.prev = s_q.level;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '{meta: 1'b1, level: 1'b1, prev: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_level = s_q.level;
  assign rx_fall = s_q.prev & ~s_q.level;
  assign rx_rise = ~s_q.prev & s_q.level;
endmodule : rx_line_sync

/* File: verilog/uart_sup.sv */
// receive supervision: auto-baud overflow handling and wake-on-break
// assumes one core clock, synchronous reset, register port in the same domain
//
// Contract
// [R1] flag overflow when counter wraps before fifth edge
// [R2] keep measuring after overflow until fifth edge
// [R3] fifth edge sets done flag, clears enable
// [R4] overflowed measurement leaves divisor untouched
// [R5] software clears done and overflow flags
// [R6] overflow irq needs four enables set
// [R7] software aborts: clear enable, then flag
// [R8] sleep stops baud clocks and reception
// [R9] wake mode suppresses reception, watches line
// [R10] leaving idle level is the wake event
// [R11] wake flag set at the wake event
// [R12] wake condition held until flag cleared
// [R13] wake irq needs three enables set
// [R14] line back idle clears wake enable
// [R15] peer sends all-zero wake character
// [R16] non-zero character: first low span wakes
// [R17] peer's break lasts eleven bits or more
// [R18] peer allows oscillator start-up time
// [R19] software checks idle before enabling wake
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_sup_cfg.svh"
module uart_sup
  import uart_sup_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire reg_req_t reg_req,
  output logic [`DATA_W-1:0] reg_rdata,
  input wire logic rx_pin,
  input wire logic core_sleep,
  input wire logic rx_frame_active,
  output logic irq,
  output logic rx_receive_enable,
  output logic [`CNT_W-1:0] baud_divisor
);
  sup_state_t st_q;
  sup_state_t st_d;
  logic rx_level;
  logic rx_fall;
  logic rx_rise;
  logic wr_ctrl0;
  logic wr_irq_flag;
  logic cnt_wrap;
  logic fifth_fall;
  logic irq_cause;
  logic rx_idle;

  // ----------------------------------------
  // receive line synchroniser
  // ----------------------------------------
  rx_line_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .rx_pin(rx_pin),
    .rx_level(rx_level),
    .rx_fall(rx_fall),
    .rx_rise(rx_rise)
  );

  assign wr_ctrl0 = reg_req.wr && (reg_req.addr == `REG_CTRL_ZERO);
  assign wr_irq_flag = reg_req.wr && (reg_req.addr == `REG_IRQ_FLAG);
  assign rx_idle = ~rx_frame_active;
  // counter steps only while awake: sleep halts the baud clock
  assign cnt_wrap = (st_q.ab_state == AB_MEASURE) && !core_sleep && (st_q.ab_cnt == `CNT_MAX); // see [R8]
  assign fifth_fall = (st_q.ab_state == AB_MEASURE) && rx_fall && (st_q.edge_cnt == `FIFTH_EDGE);
  assign irq_cause = st_q.peripheral_irq_global_enable && st_q.global_irq_enable &&
                     ((st_q.autobaud_overflow_flag && st_q.autobaud_overflow_irq_enable &&
                       st_q.port_error_irq_enable) ||
                      (st_q.port_irq_enable && |({st_q.wake_event_flag, st_q.autobaud_done_flag} &
                                                 st_q.irq_mask))); // see [R6] see [R13]

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;

    // register writes first; hardware sets below win
    if (reg_req.wr) begin
      if (reg_req.addr == `REG_CTRL_ZERO) begin
        st_d.autobaud_enable = reg_req.wdata[`BIT_AB_EN];
      end else if (reg_req.addr == `REG_CTRL_ONE) begin
        st_d.wake_on_break_enable = reg_req.wdata[`BIT_WUE];
      end else if (reg_req.addr == `REG_IRQ_FLAG) begin
        if (reg_req.wdata[`BIT_AB_DONE]) begin
          st_d.autobaud_done_flag = 1'b0; // see [R5]
        end
        if (reg_req.wdata[`BIT_WAKE]) begin
          st_d.wake_event_flag = 1'b0; // see [R12]
        end
      end else if (reg_req.addr == `REG_ERR_FLAG) begin
        if (reg_req.wdata[`BIT_AB_OVF]) begin
          st_d.autobaud_overflow_flag = 1'b0; // see [R5] see [R7]
        end
      end else if (reg_req.addr == `REG_ERR_ENABLE) begin
        st_d.autobaud_overflow_irq_enable = reg_req.wdata[`BIT_AB_OVF_IE];
      end else if (reg_req.addr == `REG_PERIPH_IE) begin
        st_d.port_irq_enable = reg_req.wdata[`BIT_PORT_IE];
        st_d.port_error_irq_enable = reg_req.wdata[`BIT_PORT_ERR_IE];
      end else if (reg_req.addr == `REG_IRQ_CTRL) begin
        st_d.peripheral_irq_global_enable = reg_req.wdata[`BIT_PIE];
        st_d.global_irq_enable = reg_req.wdata[`BIT_GIE];
      end else if (reg_req.addr == `REG_DIV_LOW) begin
        st_d.baud_div[7:0] = reg_req.wdata;
      end else if (reg_req.addr == `REG_DIV_HIGH) begin
        st_d.baud_div[15:8] = reg_req.wdata;
      end else if (reg_req.addr == `REG_IRQ_MASK) begin
        st_d.irq_mask = reg_req.wdata[1:0];
      end
    end

    // register reads, data in the following cycle only
    if (reg_req.rd) begin
      if (reg_req.addr == `REG_CTRL_ZERO) begin
        st_d.rdata[`BIT_AB_EN] = st_q.autobaud_enable;
      end else if (reg_req.addr == `REG_CTRL_ONE) begin
        st_d.rdata[`BIT_WUE] = st_q.wake_on_break_enable;
        st_d.rdata[`BIT_RX_IDLE] = rx_idle; // see [R19]
      end else if (reg_req.addr == `REG_IRQ_FLAG) begin
        st_d.rdata[`BIT_AB_DONE] = st_q.autobaud_done_flag;
        st_d.rdata[`BIT_WAKE] = st_q.wake_event_flag;
      end else if (reg_req.addr == `REG_ERR_FLAG) begin
        st_d.rdata[`BIT_AB_OVF] = st_q.autobaud_overflow_flag;
      end else if (reg_req.addr == `REG_ERR_ENABLE) begin
        st_d.rdata[`BIT_AB_OVF_IE] = st_q.autobaud_overflow_irq_enable;
      end else if (reg_req.addr == `REG_PERIPH_IE) begin
        st_d.rdata[`BIT_PORT_IE] = st_q.port_irq_enable;
        st_d.rdata[`BIT_PORT_ERR_IE] = st_q.port_error_irq_enable;
      end else if (reg_req.addr == `REG_IRQ_CTRL) begin
        st_d.rdata[`BIT_PIE] = st_q.peripheral_irq_global_enable;
        st_d.rdata[`BIT_GIE] = st_q.global_irq_enable;
      end else if (reg_req.addr == `REG_DIV_LOW) begin
        st_d.rdata = st_q.baud_div[7:0];
      end else if (reg_req.addr == `REG_DIV_HIGH) begin
        st_d.rdata = st_q.baud_div[15:8];
      end else if (reg_req.addr == `REG_IRQ_MASK) begin
        st_d.rdata[1:0] = st_q.irq_mask;
      end
    end

    // ----------------------------------------
    // auto-baud measurement
    // ----------------------------------------
    case (st_q.ab_state)
      AB_IDLE: begin
        if (st_q.autobaud_enable) begin
          st_d.ab_state = AB_WAIT_FIRST;
          st_d.ab_cnt = '0;
          st_d.ovf_seen = 1'b0;
        end
      end
      AB_WAIT_FIRST: begin
        if (!st_q.autobaud_enable) begin
          st_d.ab_state = AB_IDLE; // see [R7]
        end else if (rx_fall) begin
          st_d.ab_state = AB_MEASURE;
          st_d.edge_cnt = `EDGE_ONE;
        end
      end
      AB_MEASURE: begin
        if (!core_sleep) begin
          st_d.ab_cnt = st_q.ab_cnt + 16'h0001; // see [R8]
        end
        if (cnt_wrap) begin
          st_d.autobaud_overflow_flag = 1'b1; // see [R1]
          st_d.ovf_seen = 1'b1; // see [R2]
        end
        if (fifth_fall) begin
          st_d.ab_state = AB_IDLE;
          st_d.autobaud_done_flag = 1'b1; // see [R3]
          st_d.autobaud_enable = 1'b0; // see [R3]
          if (!st_q.ovf_seen && !cnt_wrap) begin
            st_d.baud_div = st_q.ab_cnt; // see [R4]
          end
        end else if (!st_q.autobaud_enable) begin
          st_d.ab_state = AB_IDLE; // see [R7]
        end else if (rx_fall) begin
          st_d.edge_cnt = st_q.edge_cnt + 3'h1;
        end
      end
      default: begin
        st_d.ab_state = AB_IDLE;
      end
    endcase

    // ----------------------------------------
    // wake on break
    // ----------------------------------------
    case (st_q.wk_state)
      WK_OFF: begin
        if (st_q.wake_on_break_enable && st_q.port_irq_enable) begin
          st_d.wk_state = WK_WATCH; // see [R9]
        end
      end
      WK_WATCH: begin
        if (!(st_q.wake_on_break_enable && st_q.port_irq_enable)) begin
          st_d.wk_state = WK_OFF;
        end else if (!rx_level) begin
          st_d.wk_state = WK_BREAK; // see [R10] see [R16]
          st_d.wake_event_flag = 1'b1; // see [R11]
        end
      end
      WK_BREAK: begin
        if (rx_rise || rx_level) begin
          st_d.wk_state = WK_OFF;
          st_d.wake_on_break_enable = 1'b0; // see [R14]
        end
      end
      default: begin
        st_d.wk_state = WK_OFF;
      end
    endcase

    st_d.rx_enable = !core_sleep && !st_d.autobaud_enable &&
                     !(st_d.wake_on_break_enable && st_d.port_irq_enable); // see [R8] see [R9]
    st_d.irq = irq_cause;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.ab_state <= AB_IDLE;
      st_q.wk_state <= WK_OFF;
      st_q.irq_mask <= `MASK_RESET;
      st_q.baud_div <= `DIV_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign rx_receive_enable = st_q.rx_enable;
  assign baud_divisor = st_q.baud_div;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_ovf_on_wrap: assert property (cnt_wrap |=> st_q.autobaud_overflow_flag) // see [R1]
    else $error("overflow flag missing after counter wrap");
  a_keep_after_ovf: assert property (cnt_wrap && !fifth_fall && st_q.autobaud_enable && !wr_ctrl0 |=> // see [R2]
                                     st_q.ab_state == AB_MEASURE)
    else $error("measurement stopped on overflow");
  a_fifth_done: assert property (fifth_fall |=> st_q.autobaud_done_flag && !st_q.autobaud_enable) // see [R3]
    else $error("fifth edge did not finish measurement");
  a_div_retained: assert property (fifth_fall && (st_q.ovf_seen || cnt_wrap) && !reg_req.wr |=> $stable(st_q.baud_div)) // see [R4]
    else $error("divisor changed after overflow");
  a_flag_clear: assert property (reg_req.wr && reg_req.addr == `REG_ERR_FLAG && reg_req.wdata[`BIT_AB_OVF] &&
                                 !cnt_wrap |=> !st_q.autobaud_overflow_flag) // see [R5]
    else $error("overflow flag not cleared by write");
  a_irq_gating: assert property (##1 irq == $past(irq_cause)) // see [R6] see [R13]
    else $error("interrupt output does not follow enables");
  a_sleep_halt: assert property (core_sleep && st_q.ab_state == AB_MEASURE |=> $stable(st_q.ab_cnt)) // see [R8]
    else $error("baud counter ran during sleep");
  a_wake_suppress: assert property (st_q.wake_on_break_enable && st_q.port_irq_enable |-> !rx_receive_enable) // see [R9]
    else $error("reception not suppressed in wake mode");
  a_wake_event: assert property (st_q.wk_state == WK_WATCH && st_q.wake_on_break_enable && st_q.port_irq_enable &&
                                 !rx_level |=> st_q.wake_event_flag ##1 st_q.wk_state == WK_BREAK || rx_level) // see [R11]
    else $error("wake event not flagged");
  a_wue_clear: assert property (st_q.wk_state == WK_BREAK && rx_level |=> !st_q.wake_on_break_enable) // see [R14]
    else $error("wake enable not cleared at end of break");

  // ----------------------------------------
  // assertions: flags, divisor, sleep, abort, wake arming, interrupt
  // ----------------------------------------
  a_ovf_hold: assert property (st_q.autobaud_overflow_flag && // see [R5]
                               !(reg_req.wr && reg_req.addr == `REG_ERR_FLAG && reg_req.wdata[`BIT_AB_OVF])
                               |=> st_q.autobaud_overflow_flag)
    else $error("overflow flag lost without a clear");
  a_done_clear: assert property (wr_irq_flag && reg_req.wdata[`BIT_AB_DONE] && !fifth_fall |=> // see [R5]
                                 !st_q.autobaud_done_flag)
    else $error("done flag not cleared by write");
  a_wake_clear: assert property (wr_irq_flag && reg_req.wdata[`BIT_WAKE] && // see [R12]
                                 !(st_q.wk_state == WK_WATCH && st_q.wake_on_break_enable && st_q.port_irq_enable &&
                                   !rx_level) |=> !st_q.wake_event_flag)
    else $error("wake flag not cleared by write");
  a_wake_hold: assert property (st_q.wake_event_flag && !(wr_irq_flag && reg_req.wdata[`BIT_WAKE]) |=> // see [R12]
                                st_q.wake_event_flag)
    else $error("wake flag dropped without a clear");
  a_div_update: assert property (fifth_fall && !st_q.ovf_seen && !cnt_wrap |=> // see [R4]
                                 baud_divisor == $past(st_q.ab_cnt))
    else $error("divisor not loaded by clean measurement");
  a_sleep_no_rx: assert property (core_sleep |=> !rx_receive_enable) // see [R8]
    else $error("reception enabled during sleep");
  a_abort_idle: assert property (st_q.ab_state != AB_IDLE && !st_q.autobaud_enable |=> // see [R7]
                                 st_q.ab_state == AB_IDLE)
    else $error("measurement not abandoned when enable cleared");
  a_wake_watch: assert property (st_q.wk_state == WK_OFF && st_q.wake_on_break_enable && // see [R9]
                                 st_q.port_irq_enable |=> st_q.wk_state == WK_WATCH)
    else $error("wake monitor not armed");
  a_irq_off: assert property (!(st_q.peripheral_irq_global_enable && st_q.global_irq_enable) |=> // see [R6] see [R13]
                              !irq)
    else $error("interrupt raised without global enables");
  a_ovf_irq: assert property (st_q.autobaud_overflow_flag && st_q.autobaud_overflow_irq_enable && // see [R6]
                              st_q.port_error_irq_enable && st_q.peripheral_irq_global_enable &&
                              st_q.global_irq_enable |=> irq)
    else $error("overflow interrupt not raised");
  a_wake_irq: assert property (st_q.wake_event_flag && st_q.irq_mask[`BIT_WAKE] && // see [R13]
                               st_q.port_irq_enable && st_q.peripheral_irq_global_enable &&
                               st_q.global_irq_enable |=> irq)
    else $error("wake interrupt not raised");
endmodule : uart_sup

/* File: dv/rx_peer.sv */
// remote transmitter model driving the receive line
// assumes the line idles high and the bench calls drive()
`timescale 1ns/1ps
module rx_peer (
  input wire logic core_clk,
  output logic rx_pin
);
  // ----------------------------------------
  // line driver
  // ----------------------------------------
  initial begin
    rx_pin = 1'b1;
  end

  // hold a level for n clock cycles
  task automatic drive(input logic v, input int n);
    rx_pin <= v;
    repeat (n) @(posedge core_clk);
  endtask : drive

  // ----------------------------------------
  // framed traffic
  // ----------------------------------------
  // n falls two bit times apart, like a 0x55 sync byte
  task automatic falls(input int n, input int bit_cyc);
    for (int i = 0; i < n; i++) begin
      drive(1'b0, bit_cyc);
      drive(1'b1, bit_cyc);
    end
  endtask : falls

  // all-zero break of 13 bits, then idle time
  task automatic brk_tail(input int bit_cyc);
    drive(1'b0, 13 * bit_cyc);
    drive(1'b1, 4 * bit_cyc);
  endtask : brk_tail
endmodule : rx_peer

/* File: dv/uart_sup_tb_top.sv */
// self-checking bench for the receive supervision block
// assumes uart_sup_pkg compiled first; rx_peer drives the line
`timescale 1ns/1ps
module uart_sup_tb_top
  import uart_sup_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;

  logic core_clk;
  logic reset;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic rx_pin;
  logic core_sleep;
  logic rx_frame_active;
  logic irq;
  logic rx_receive_enable;
  logic [15:0] baud_divisor;
  int n_errors;
  int checks;
  localparam int B = 16;
  row_t rows [8] = '{'{4'h4, 8'h01, 8'h01}, '{4'h5, 8'h02, 8'h02}, '{4'h6, 8'h00, 8'h00},
    '{4'h7, 8'h34, 8'h34}, '{4'h8, 8'h12, 8'h12}, '{4'h9, 8'h03, 8'h03},
    '{4'ha, 8'hff, 8'h00}, '{4'hf, 8'hff, 8'h00}};

  // ----------------------------------------
  // clock, instances
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  uart_sup DUT (.core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rx_pin(rx_pin), .core_sleep(core_sleep), .rx_frame_active(rx_frame_active), .irq(irq),
    .rx_receive_enable(rx_receive_enable), .baud_divisor(baud_divisor));

  rx_peer peer (.core_clk(core_clk), .rx_pin(rx_pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rchk

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0;
    checks = 0;
    reset = 1'b1;
    reg_req = '0;
    core_sleep = 1'b0;
    rx_frame_active = 1'b0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    chk({15'h0, rx_receive_enable}, 16'h1);
    chk({15'h0, irq}, 16'h0);
    chk(baud_divisor, 16'h0000);
    rchk(4'h9, 8'h03);
    rchk(4'h2, 8'h00);
    // register rows, unmapped places read zero
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk(baud_divisor, 16'h1234);
    // overflow: one fall, then a long idle line
    wr(4'h0, 8'h01);
    peer.falls(1, B);
    repeat (65600) @(posedge core_clk);
    rchk(4'h3, 8'h01);
    rchk(4'h0, 8'h01);
    chk({15'h0, irq}, 16'h0);
    wr(4'h6, 8'h01);
    settle();
    chk({15'h0, irq}, 16'h0);
    wr(4'h6, 8'h03);
    settle();
    chk({15'h0, irq}, 16'h1);
    peer.falls(4, B);
    repeat (8) @(posedge core_clk);
    rchk(4'h2, 8'h01);
    rchk(4'h0, 8'h00);
    chk(baud_divisor, 16'h1234);
    wr(4'h3, 8'h01);
    rchk(4'h3, 8'h00);
    settle();
    chk({15'h0, irq}, 16'h0);
    wr(4'h2, 8'h01);
    rchk(4'h2, 8'h00);
    // clean measurement, done interrupt through port enable
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
    settle();
    chk({15'h0, rx_receive_enable}, 16'h0);
    peer.falls(5, B);
    repeat (8) @(posedge core_clk);
    rchk(4'h2, 8'h01);
    rchk(4'h3, 8'h00);
    chk({15'h0, baud_divisor inside {[16'h007e:16'h0080]}}, 16'h1);
    chk({15'h0, irq}, 16'h1);
    wr(4'h2, 8'h01);
    settle();
    chk({15'h0, irq}, 16'h0);
    // abort: enable off first, then overflow flag
    wr(4'h0, 8'h01);
    peer.falls(1, B);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h01);
    peer.falls(5, B);
    repeat (8) @(posedge core_clk);
    rchk(4'h2, 8'h00);
    // idle status before enabling wake
    rx_frame_active <= 1'b1;
    rchk(4'h1, 8'h00);
    rx_frame_active <= 1'b0;
    rchk(4'h1, 8'h02);
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h01);
    core_sleep <= 1'b1;
    settle();
    chk({15'h0, rx_receive_enable}, 16'h0);
    peer.drive(1'b0, 8);
    rchk(4'h2, 8'h02);
    chk({15'h0, irq}, 16'h0);
    wr(4'h6, 8'h03);
    settle();
    chk({15'h0, irq}, 16'h1);
    rchk(4'h1, 8'h03);
    peer.brk_tail(B);
    rchk(4'h1, 8'h02);
    rchk(4'h2, 8'h02);
    chk({15'h0, irq}, 16'h1);
    wr(4'h2, 8'h02);
    settle();
    chk({15'h0, irq}, 16'h0);
    core_sleep <= 1'b0;
    settle();
    chk({15'h0, rx_receive_enable}, 16'h1);
    // non-zero character: start bit low span only
    wr(4'h1, 8'h01);
    peer.drive(1'b0, B);
    peer.drive(1'b1, 9 * B);
    rchk(4'h1, 8'h02);
    rchk(4'h2, 8'h02);
    chk({15'h0, irq}, 16'h1);
    // mid-run reset while the wake flag drives the interrupt
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    chk({15'h0, irq}, 16'h0);
    chk({15'h0, rx_receive_enable}, 16'h1);
    chk(baud_divisor, 16'h0000);
    rchk(4'h2, 8'h00);
    rchk(4'h9, 8'h03);
    summarize();
  end
endmodule : uart_sup_tb_top
